//--- rtl/cat_timebase.sv
// shared time base, mode and control registers and port 1 routing of the counter array
// Operation
// - one dedicated counter is the time base for all five modules
// - select field picks osc/12, osc/4, timer 0 overflow or external input
// - double-speed mode halves internal ratios to osc/6 and osc/2
// - idle gate bit 0 keeps counting in idle, 1 stops it
// - module 4 watchdog is enabled only while its enable bit is set
// - overflow flag raises an interrupt only when its enable bit is set
// - five module requests and counter overflow share one interrupt output
// - external input on port bit 2, modules 0 to 4 on bits 3 to 7
// - modules offer capture, software timer, fast output, pwm; module 4 watchdog
// - capture, timer and fast-output functions may raise a request
// - counter advances only while the run bit of control register is set
// - overflow sets flag bit 7; only software clears it
module cat_timebase (
    input wire logic clock,
    input wire logic rst_n,
    input wire cat_pkg::cat_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    input wire logic idle_mode,
    input wire logic double_speed_mode,
    input wire logic timer0_overflow,
    input wire logic [cat_pkg::NUM_MODULES-1:0] module_event,
    input wire logic [cat_pkg::NUM_MODULES-1:0] module_irq_enable,
    input wire logic [cat_pkg::NUM_MODULES-1:0] module_drive,
    input wire logic [cat_pkg::NUM_MODULES-1:0] module_out_level,
    input wire logic [7:0] port_latch,
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [cat_pkg::NUM_MODULES-1:0] module_in_level,
    output logic [cat_pkg::COUNT_W-1:0] count_value,
    output logic count_step,
    output logic counter_running,
    output logic watchdog_active,
    output logic array_irq
);
    cat_pkg::cat_mode_t mode;
    cat_pkg::cat_control_t control;
    logic tick_slow;
    logic tick_fast;
    logic [2:0] ext_sync;
    logic ext_level;
    logic ext_fall;
    logic source_pulse;
    logic count_load;
    logic overflow;
    logic [7:0] mode_byte;
    logic [7:0] control_byte;
    logic wr_mode;
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;

    // both internal rates share one divider, so a source switch keeps the phase
    cat_prescaler u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .double_speed_mode(double_speed_mode),
        .tick_slow(tick_slow),
        .tick_fast(tick_fast)
    );

    assign wr_mode = sfr_req.wr && sfr_req.addr == cat_pkg::ADDR_MODE;
    assign wr_ctrl = sfr_req.wr && sfr_req.addr == cat_pkg::ADDR_CONTROL;
    assign wr_lo = sfr_req.wr && sfr_req.addr == cat_pkg::ADDR_COUNT_LO;
    assign wr_hi = sfr_req.wr && sfr_req.addr == cat_pkg::ADDR_COUNT_HI;

    // external count pin: third stage only confirms the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync <= 3'h7;
            ext_level <= 1'b1;
        end else begin
            ext_sync <= {ext_sync[1:0], port_pin_in[cat_pkg::PIN_EXT_COUNT]};
            if (ext_sync[1] == ext_sync[2]) begin
                ext_level <= ext_sync[2];
            end
        end
    end

    // falling edge of the filtered level is the count event
    assign ext_fall = ext_level && ext_sync[1] == ext_sync[2] && !ext_sync[2];

    // one three-stage filter per module pin, read back for capture logic
    for (genvar gi = 0; gi < cat_pkg::NUM_MODULES; gi++) begin : g_module_pin
        logic stage1;
        logic stage2;
        logic stage3;
        logic level;

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                stage1 <= 1'b0;
                stage2 <= 1'b0;
                stage3 <= 1'b0;
                level <= 1'b0;
            end else begin
                stage1 <= port_pin_in[cat_pkg::PIN_MODULE0 + gi];
                stage2 <= stage1;
                stage3 <= stage2;
                if (stage2 == stage3) begin
                    level <= stage3;
                end
            end
        end
        assign module_in_level[gi] = level;

        // array drives a module pin only while that module claims it
        assign port_pin_out[cat_pkg::PIN_MODULE0 + gi] = module_drive[gi] ? module_out_level[gi]
            : port_latch[cat_pkg::PIN_MODULE0 + gi];
    end

    // pins below the modules stay ordinary port outputs
    assign port_pin_out[cat_pkg::PIN_MODULE0-1:0] = port_latch[cat_pkg::PIN_MODULE0-1:0];

    always_comb begin
        case (mode.source)
            cat_pkg::CAT_SRC_SLOW: source_pulse = tick_slow;
            cat_pkg::CAT_SRC_FAST: source_pulse = tick_fast;
            cat_pkg::CAT_SRC_TIMER0: source_pulse = timer0_overflow;
            cat_pkg::CAT_SRC_EXT: source_pulse = ext_fall;
            default: source_pulse = 1'b0;
        endcase
    end

    assign counter_running = control.counter_run_bit &&
        !(idle_mode && mode.idle_gate_bit);
    assign count_load = wr_lo || wr_hi;
    assign count_step = counter_running && source_pulse;
    // a load in the same cycle replaces the wrap, so it must not raise the flag
    assign overflow = count_step && !count_load && count_value == cat_pkg::COUNT_MAX;

    // single time base seen by all five modules
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= cat_pkg::COUNT_RESET;
        end else if (wr_lo) begin
            count_value[7:0] <= sfr_req.wdata;
        end else if (wr_hi) begin
            count_value[15:8] <= sfr_req.wdata;
        end else if (count_step) begin
            count_value <= count_value + 1'b1;
        end
    end

    // reserved bits are not stored and read back as zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode.idle_gate_bit <= cat_pkg::MODE_RESET[cat_pkg::MODE_IDLE_GATE_POS];
            mode.watchdog_enable_bit <= cat_pkg::MODE_RESET[cat_pkg::MODE_WDT_EN_POS];
            mode.source <= cat_pkg::cat_source_t'({
                cat_pkg::MODE_RESET[cat_pkg::MODE_SEL_HI_POS],
                cat_pkg::MODE_RESET[cat_pkg::MODE_SEL_LO_POS]});
            mode.overflow_irq_enable <= cat_pkg::MODE_RESET[cat_pkg::MODE_OVF_IE_POS];
        end else if (wr_mode) begin
            mode.idle_gate_bit <= sfr_req.wdata[cat_pkg::MODE_IDLE_GATE_POS];
            mode.watchdog_enable_bit <= sfr_req.wdata[cat_pkg::MODE_WDT_EN_POS];
            mode.source <= cat_pkg::cat_source_t'({sfr_req.wdata[cat_pkg::MODE_SEL_HI_POS],
                sfr_req.wdata[cat_pkg::MODE_SEL_LO_POS]});
            mode.overflow_irq_enable <= sfr_req.wdata[cat_pkg::MODE_OVF_IE_POS];
        end
    end

    // hardware set beats a software clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control.counter_overflow_flag <= cat_pkg::CTRL_RESET[cat_pkg::CTRL_OVF_FLAG_POS];
            control.counter_run_bit <= cat_pkg::CTRL_RESET[cat_pkg::CTRL_RUN_POS];
            control.module_flag <=
                cat_pkg::CTRL_RESET[cat_pkg::CTRL_MOD_FLAG_LSB +: cat_pkg::NUM_MODULES];
        end else begin
            if (wr_ctrl) begin
                control.counter_run_bit <= sfr_req.wdata[cat_pkg::CTRL_RUN_POS];
            end
            control.counter_overflow_flag <= overflow ||
                (wr_ctrl ? sfr_req.wdata[cat_pkg::CTRL_OVF_FLAG_POS]
                         : control.counter_overflow_flag);
            control.module_flag <= module_event |
                (wr_ctrl ? sfr_req.wdata[cat_pkg::CTRL_MOD_FLAG_LSB +: cat_pkg::NUM_MODULES]
                         : control.module_flag);
        end
    end

    assign array_irq = (control.counter_overflow_flag && mode.overflow_irq_enable) ||
        |(control.module_flag & module_irq_enable);
    assign watchdog_active = mode.watchdog_enable_bit;

    // software view of both registers, assembled at the field positions
    always_comb begin
        mode_byte = 8'h00;
        mode_byte[cat_pkg::MODE_IDLE_GATE_POS] = mode.idle_gate_bit;
        mode_byte[cat_pkg::MODE_WDT_EN_POS] = mode.watchdog_enable_bit;
        {mode_byte[cat_pkg::MODE_SEL_HI_POS], mode_byte[cat_pkg::MODE_SEL_LO_POS]} = mode.source;
        mode_byte[cat_pkg::MODE_OVF_IE_POS] = mode.overflow_irq_enable;
        control_byte = 8'h00;
        control_byte[cat_pkg::CTRL_OVF_FLAG_POS] = control.counter_overflow_flag;
        control_byte[cat_pkg::CTRL_RUN_POS] = control.counter_run_bit;
        control_byte[cat_pkg::CTRL_MOD_FLAG_LSB +: cat_pkg::NUM_MODULES] = control.module_flag;
    end

    // read answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
            sfr_rvalid <= 1'b0;
        end else begin
            sfr_rvalid <= sfr_req.rd;
            if (sfr_req.rd) begin
                case (sfr_req.addr)
                    cat_pkg::ADDR_MODE: sfr_rdata <= mode_byte;
                    cat_pkg::ADDR_CONTROL: sfr_rdata <= control_byte;
                    cat_pkg::ADDR_COUNT_LO: sfr_rdata <= count_value[7:0];
                    cat_pkg::ADDR_COUNT_HI: sfr_rdata <= count_value[15:8];
                    default: sfr_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

//--- rtl/cat_pkg.sv
// constants and types shared by the counter array time base
package cat_pkg;
    // register addresses on the special function register port
    localparam logic [7:0] ADDR_CONTROL = 8'hd8;
    localparam logic [7:0] ADDR_MODE = 8'hd9;
    localparam logic [7:0] ADDR_COUNT_LO = 8'he9;
    localparam logic [7:0] ADDR_COUNT_HI = 8'hf9;

    // mode register field positions
    localparam int MODE_IDLE_GATE_POS = 7;
    localparam int MODE_WDT_EN_POS = 6;
    localparam int MODE_SEL_HI_POS = 2;
    localparam int MODE_SEL_LO_POS = 1;
    localparam int MODE_OVF_IE_POS = 0;

    // control register field positions
    localparam int CTRL_OVF_FLAG_POS = 7;
    localparam int CTRL_RUN_POS = 6;
    localparam int CTRL_MOD_FLAG_LSB = 0;

    localparam int NUM_MODULES = 5;
    localparam int COUNT_W = 16;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // prescale ratios in oscillator cycles
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int DIV_SLOW_X2 = DIV_SLOW / 2;
    localparam int DIV_FAST_X2 = DIV_FAST / 2;
    localparam int PRESCALE_W = 4;

    // port 1 bit positions
    localparam int PIN_EXT_COUNT = 2;
    localparam int PIN_MODULE0 = 3;

    typedef enum logic [1:0] {
        CAT_SRC_SLOW = 2'h0,
        CAT_SRC_FAST = 2'h1,
        CAT_SRC_TIMER0 = 2'h2,
        CAT_SRC_EXT = 2'h3
    } cat_source_t;

    typedef struct packed {
        logic idle_gate_bit;
        logic watchdog_enable_bit;
        cat_source_t source;
        logic overflow_irq_enable;
    } cat_mode_t;

    typedef struct packed {
        logic counter_overflow_flag;
        logic counter_run_bit;
        logic [NUM_MODULES-1:0] module_flag;
    } cat_control_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cat_sfr_req_t;
endpackage

//--- rtl/cat_prescaler.sv
// internal count pulse generator for the array counter
module cat_prescaler (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic double_speed_mode,
    output logic tick_slow,
    output logic tick_fast
);
    logic [cat_pkg::PRESCALE_W-1:0] phase;

    // one free-running phase counter serves both ratios, so they stay aligned
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
        end else if (phase == cat_pkg::PRESCALE_W'(cat_pkg::DIV_SLOW - 1)) begin
            phase <= '0;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    always_comb begin
        if (double_speed_mode) begin
            tick_slow = (phase % cat_pkg::PRESCALE_W'(cat_pkg::DIV_SLOW_X2)) == '0;
            tick_fast = (phase % cat_pkg::PRESCALE_W'(cat_pkg::DIV_FAST_X2)) == '0;
        end else begin
            tick_slow = phase == '0;
            tick_fast = (phase % cat_pkg::PRESCALE_W'(cat_pkg::DIV_FAST)) == '0;
        end
    end
endmodule

//--- dv/cat_event_src.sv
// far-side model: external count pin and timer 0 overflow pulses
module cat_event_src (
    input wire logic clock,
    input wire logic rst_n,
    output logic ext_pin,
    output logic t0_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase;
    always_ff @(negedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 3'h0;
        end else begin
            phase <= phase + 3'h1;
        end
    end
    // period of eight cycles, the fastest the pin may toggle; idles high after reset
    assign ext_pin = ~phase[2];
    assign t0_overflow = (phase == 3'h7);
endmodule

//--- dv/cat_timebase_sva.sv
// port assertions for the counter array time base
module cat_timebase_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire cat_pkg::cat_sfr_req_t sfr_req,
    input wire logic sfr_rvalid,
    input wire logic idle_mode,
    input wire logic [cat_pkg::NUM_MODULES-1:0] module_drive,
    input wire logic [cat_pkg::NUM_MODULES-1:0] module_out_level,
    input wire logic [7:0] port_latch,
    input wire logic [7:0] port_pin_out,
    input wire logic [cat_pkg::COUNT_W-1:0] count_value,
    input wire logic count_step,
    input wire logic counter_running,
    input wire logic watchdog_active,
    input wire logic array_irq
);
    logic [7:0] mode_q;
    logic mode_wr;
    assign mode_wr = sfr_req.wr && sfr_req.addr == cat_pkg::ADDR_MODE;
    // shadow of the mode register, reserved bits never matter here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
        end else if (mode_wr) begin
            mode_q <= sfr_req.wdata;
        end
    end
    logic run_q;
    // shadow of the run bit, so the gating check does not lean on the design
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (sfr_req.wr && sfr_req.addr == cat_pkg::ADDR_CONTROL) begin
            run_q <= sfr_req.wdata[6];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rd_ans; sfr_req.rd |=> sfr_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_pulse; !sfr_req.rd |=> !sfr_rvalid; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("spurious read answer");
    property p_inc; count_step && !sfr_req.wr |=> count_value == $past(count_value) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not step");
    property p_hold; !count_step && !sfr_req.wr |=> $stable(count_value); endproperty
    a_hold: assert property (p_hold) else $error("count moved without pulse");
    property p_run; !run_q && !sfr_req.wr |=> $stable(count_value); endproperty
    a_run: assert property (p_run) else $error("count moved while stopped");
    property p_gate; counter_running == (run_q && !(idle_mode && mode_q[7])); endproperty
    a_gate: assert property (p_gate) else $error("run gating wrong");
    property p_idle; idle_mode && mode_q[7] |-> !counter_running; endproperty
    a_idle: assert property (p_idle) else $error("counting in gated idle");
    property p_wdt; mode_wr ##1 !mode_wr |=> watchdog_active == mode_q[6]; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog enable mismatch");
    property p_ovf_irq;
        count_step && count_value == 16'hffff && mode_q[0] && !sfr_req.wr |=> array_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");
    property p_pins; port_pin_out == ((port_latch & ~{module_drive, 3'h0})
        | ({module_out_level, 3'h0} & {module_drive, 3'h0})); endproperty
    a_pins: assert property (p_pins) else $error("port routing wrong");
endmodule

//--- dv/testbench.sv
// self-checking bench for the counter array time base
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, idle_mode = 0, ds = 0, ext_pin, t0_ovf, irq, running, wdt;
    cat_pkg::cat_sfr_req_t sfr_req = '0;
    logic [4:0] ev = 0, ie = 0, drv = 0, lvl = 0, pins_hi = 0, in_lvl;
    logic [7:0] latch = 0, rdata, pin_out;
    logic rvalid;
    int mismatches = 0, cmp_count = 0;
    logic [7:0] exp_cnt [8] = '{8'h04, 8'h08, 8'h0c, 8'h18, 8'h06, 8'h06, 8'h06, 8'h06};
    cat_event_src i_cat_event_src (.clock(clock), .rst_n(rst_n), .ext_pin(ext_pin),
        .t0_overflow(t0_ovf));
    cat_timebase i_cat_timebase (.clock(clock), .rst_n(rst_n), .sfr_req(sfr_req),
        .sfr_rdata(rdata), .sfr_rvalid(rvalid), .idle_mode(idle_mode), .double_speed_mode(ds),
        .timer0_overflow(t0_ovf), .module_event(ev), .module_irq_enable(ie),
        .module_drive(drv), .module_out_level(lvl), .port_latch(latch),
        .port_pin_in({pins_hi, ext_pin, 2'h3}), .port_pin_out(pin_out),
        .module_in_level(in_lvl), .count_value(), .count_step(), .counter_running(running),
        .watchdog_active(wdt), .array_irq(irq));
    initial begin
        forever #20 clock = ~clock;
    end
    // the request drops for a full cycle, so two calls never touch it in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clock);
        sfr_req = '0;
        @(negedge clock);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] v);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        sfr_req = '0;
        `CHK({rvalid, rdata}, {1'b1, v})
        @(negedge clock);
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1;
        rdchk(cat_pkg::ADDR_CONTROL, 8'h00);
        rdchk(cat_pkg::ADDR_MODE, 8'h00);
        rdchk(8'h00, 8'h00);
        wr(cat_pkg::ADDR_MODE, 8'h47);
        rdchk(cat_pkg::ADDR_MODE, 8'h47);
        `CHK(wdt, 1'b1)
        wr(cat_pkg::ADDR_MODE, 8'h00);
        @(negedge clock);
        `CHK(wdt, 1'b0)
        // every source and speed over a window of exactly 48 edges
        for (int s = 0; s < 8; s++) begin
            ds = s[0];
            wr(cat_pkg::ADDR_COUNT_LO, 8'h00);
            wr(cat_pkg::ADDR_COUNT_HI, 8'h00);
            wr(cat_pkg::ADDR_MODE, {5'h00, s[2:1], 1'b0});
            wr(cat_pkg::ADDR_CONTROL, 8'h40);
            repeat (46) @(negedge clock);
            wr(cat_pkg::ADDR_CONTROL, 8'h00);
            rdchk(cat_pkg::ADDR_COUNT_LO, exp_cnt[s]);
            rdchk(cat_pkg::ADDR_COUNT_HI, 8'h00);
        end
        wr(cat_pkg::ADDR_COUNT_LO, 8'hff);
        wr(cat_pkg::ADDR_COUNT_HI, 8'hff);
        wr(cat_pkg::ADDR_MODE, 8'h03);
        wr(cat_pkg::ADDR_CONTROL, 8'h40);
        repeat (12) @(negedge clock);
        rdchk(cat_pkg::ADDR_CONTROL, 8'hc0);
        `CHK(irq, 1'b1)
        wr(cat_pkg::ADDR_MODE, 8'h02);
        `CHK(irq, 1'b0)
        wr(cat_pkg::ADDR_CONTROL, 8'h00);
        rdchk(cat_pkg::ADDR_CONTROL, 8'h00);
        wr(cat_pkg::ADDR_MODE, 8'h80);
        wr(cat_pkg::ADDR_CONTROL, 8'h40);
        idle_mode = 1;
        @(negedge clock);
        `CHK(running, 1'b0)
        wr(cat_pkg::ADDR_MODE, 8'h00);
        `CHK(running, 1'b1)
        idle_mode = 0;
        wr(cat_pkg::ADDR_CONTROL, 8'h00);
        ie = 5'h04;
        ev = 5'h05;
        @(negedge clock);
        ev = 5'h00;
        `CHK(irq, 1'b1)
        rdchk(cat_pkg::ADDR_CONTROL, 8'h05);
        wr(cat_pkg::ADDR_CONTROL, 8'h00);
        `CHK(irq, 1'b0)
        latch = 8'ha5;
        drv = 5'h0f;
        lvl = 5'h0a;
        pins_hi = 5'h15;
        repeat (5) @(negedge clock);
        `CHK(pin_out, 8'hd5)
        `CHK(in_lvl, 5'h15)
        stop_test();
    end
endmodule
bind cat_timebase cat_timebase_sva i_cat_timebase_sva (.clock(clock), .rst_n(rst_n),
    .sfr_req(sfr_req), .sfr_rvalid(sfr_rvalid), .idle_mode(idle_mode),
    .module_drive(module_drive), .module_out_level(module_out_level),
    .port_latch(port_latch), .port_pin_out(port_pin_out), .count_value(count_value),
    .count_step(count_step), .counter_running(counter_running),
    .watchdog_active(watchdog_active), .array_irq(array_irq));
